// ===== hbwa_pkg.sv
// shared constants for the host bus width adapter
package hbwa_pkg;
  localparam int          DATA_W        = 32;
  localparam int          HALF_W        = 16;
  localparam int          ADDR_W        = 8;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          LVL_W         = 4;
  localparam logic [3:0]  RX_READY_LVL  = 4'h6;
  localparam logic [7:0]  OFS_DATA      = 8'h00;
  localparam logic [7:0]  OFS_CFG       = 8'h04;
  localparam logic [7:0]  OFS_SWAP      = 8'h08;
  localparam int          CFG_RXAVAIL   = 0;
  localparam int          CFG_TXSPACE   = 1;
  localparam int          CFG_WIDTH16   = 2;
  localparam logic [31:0] SWAP_RESET    = 32'h00000000;
  localparam logic [31:0] SWAP_ALL_ONES = 32'hffffffff;
endpackage

// ===== hbwa_bus_if.sv
// host bus between the processor end and the controller end
`timescale 1ns/1ps
interface hbwa_bus_if;
  logic        strapWidth16;
  logic [7:0]  addr;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [31:0] hostData;
  logic        hostOe;
  logic [31:0] devData;
  logic        devOeLo;
  logic        devOeHi;
  logic        ack;
  logic        txSpace;
  logic [31:0] dataBus;

  // wire level; undriven lanes sit low through the pull-downs
  always_comb begin
    dataBus = 32'h00000000;
    if (hostOe) begin
      dataBus = hostData;
    end else begin
      if (devOeLo) dataBus[15:0] = devData[15:0];
      if (devOeHi) dataBus[31:16] = devData[31:16];
    end
  end

  modport device (input strapWidth16, addr, wrStrobe, rdStrobe, dataBus,
                  output devData, devOeLo, devOeHi, ack, txSpace);
  modport host (output strapWidth16, addr, wrStrobe, rdStrobe, hostData, hostOe,
                input dataBus, ack, txSpace);
endinterface

// ===== hbwa_device.sv
// controller end: width adapter, registers and the two data fifos
// Function
// - strap picks width, shown at config bit 2
// - host writes dword as two halves
// - host keeps A2 and up fixed
// - halves written in either order
// - same half written twice discards dword
// - dword read as two opposite halves
// - same half read twice restarts read pairing
// - host re-reads after a repeated half
// - upper lanes not driven in 16-bit, except low by host writes
// - 32-bit mode ignores swap setting
// - swap governs registers and fifos alike
// - normal: A1 low maps low word
// - all ones: A1 low maps high word
// - low word first to and from network
`timescale 1ns/1ps
module hbwa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic [WIDTH-1:0]           inData,
  input  wire logic                       inValid,
  output logic                            inReady,
  output logic [WIDTH-1:0]                outData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW-1:0]    next_wrPtr;
  logic [PW-1:0]    next_rdPtr;
  logic [$clog2(DEPTH+1)-1:0] next_level;
  logic             push;
  logic             pop;

  assign inReady  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign outValid = (level != '0);
  assign outData  = mem[rdPtr];

  always_comb begin
    push       = inValid && inReady;
    pop        = outValid && outReady;
    next_wrPtr = push ? PW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = pop ? PW'(rdPtr + 1'b1) : rdPtr;
    next_level = level;
    if (push && !pop) next_level = level + 1'b1;
    if (pop && !push) next_level = level - 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      level <= next_level;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wrPtr] <= inData;
  end
endmodule

module hbwa_device (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  hbwa_bus_if.device                     bus,
  output logic [hbwa_pkg::HALF_W-1:0]    txHalf,
  output logic                           txHalfValid,
  input  wire logic                      txHalfReady,
  input  wire logic [hbwa_pkg::HALF_W-1:0] rxHalf,
  input  wire logic                      rxHalfValid,
  output logic                           rxHalfReady
);
  import hbwa_pkg::*;

  logic        strapMeta;
  logic        strapSync;
  logic        strapTaken;
  logic [2:0]  strapAge;
  logic        mode16;
  logic [31:0] swapReg;
  logic        wrPending;
  logic        wrHalf;
  logic [15:0] stage;
  logic        rdPending;
  logic [31:0] rdLatch;
  logic        txPhase;
  logic        rxHave;
  logic [15:0] rxLo;
  logic        next_strapTaken;
  logic [2:0]  next_strapAge;
  logic        next_mode16;
  logic [31:0] next_swapReg;
  logic        next_wrPending;
  logic        next_wrHalf;
  logic [15:0] next_stage;
  logic        next_rdPending;
  logic [31:0] next_rdLatch;
  logic [31:0] next_devData;
  logic        next_devOeLo;
  logic        next_devOeHi;
  logic        next_ack;
  logic        next_txSpace;
  logic        next_txPhase;
  logic [15:0] next_txHalf;
  logic        next_txHalfValid;
  logic        next_rxHave;
  logic [15:0] next_rxLo;
  logic        next_rxHalfReady;
  logic        swapOn;
  logic        half;
  logic        commitEn;
  logic [31:0] commitData;
  logic [31:0] fetched;
  logic        txPush;
  logic        txInReady;
  logic [31:0] txOutData;
  logic        txOutValid;
  logic        txPop;
  logic        rxPush;
  logic [31:0] rxPushData;
  logic [31:0] rxOutData;
  logic        rxOutValid;
  logic        rxPop;
  logic [3:0]  rxLevel;

  function automatic logic hitDword(input logic [7:0] a, input logic [7:0] ofs);
    hitDword = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [15:0] pickHalf(input logic [31:0] w, input logic hi);
    pickHalf = hi ? w[31:16] : w[15:0];
  endfunction

  hbwa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) txFifo (
    .clk(clk), .resetn(resetn), .inData(commitData), .inValid(txPush), .inReady(txInReady),
    .outData(txOutData), .outValid(txOutValid), .outReady(txPop), .level()
  );

  hbwa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk(clk), .resetn(resetn), .inData(rxPushData), .inValid(rxPush), .inReady(),
    .outData(rxOutData), .outValid(rxOutValid), .outReady(rxPop), .level(rxLevel)
  );

  always_comb begin
    next_strapTaken  = strapTaken;
    next_strapAge    = {strapAge[1:0], 1'b1};
    next_mode16      = mode16;
    next_swapReg     = swapReg;
    next_wrPending   = wrPending;
    next_wrHalf      = wrHalf;
    next_stage       = stage;
    next_rdPending   = rdPending;
    next_rdLatch     = rdLatch;
    next_devData     = 32'h00000000;
    next_devOeLo     = 1'b0;
    next_devOeHi     = 1'b0;
    next_ack         = 1'b0;
    next_txPhase     = txPhase;
    next_txHalf      = txHalf;
    next_txHalfValid = txHalfValid;
    next_rxHave      = rxHave;
    next_rxLo        = rxLo;
    commitEn         = 1'b0;
    commitData       = bus.dataBus;
    txPush           = 1'b0;
    txPop            = 1'b0;
    rxPop            = 1'b0;
    rxPush           = 1'b0;
    rxPushData       = {rxHalf, rxLo};
    fetched          = 32'h00000000;
    // width strap caught once the synchroniser holds the driven level
    if (!strapTaken && strapAge[2]) begin
      next_strapTaken = 1'b1;
      next_mode16     = strapSync;
    end
    swapOn = mode16 && (swapReg == SWAP_ALL_ONES);
    half   = bus.addr[1] ^ swapOn;
    // writes
    if (bus.wrStrobe) begin
      next_ack = 1'b1;
      if (!mode16) begin
        commitEn = 1'b1;
      end else if (!wrPending) begin
        next_wrPending = 1'b1;
        next_wrHalf    = half;
        next_stage     = bus.dataBus[15:0];
      end else begin
        next_wrPending = 1'b0;
        if (half != wrHalf) begin
          commitEn   = 1'b1;
          commitData = half ? {bus.dataBus[15:0], stage} : {stage, bus.dataBus[15:0]};
        end
        // same half again: whole dword dropped
      end
    end
    if (commitEn) begin
      if (hitDword(bus.addr, OFS_SWAP)) next_swapReg = commitData;
      if (hitDword(bus.addr, OFS_DATA)) txPush = 1'b1;
    end
    // reads
    if (hitDword(bus.addr, OFS_CFG)) begin
      fetched[CFG_RXAVAIL] = rxOutValid;
      fetched[CFG_TXSPACE] = txInReady;
      fetched[CFG_WIDTH16] = mode16;
    end else if (hitDword(bus.addr, OFS_SWAP)) begin
      fetched = swapReg;
    end else if (hitDword(bus.addr, OFS_DATA)) begin
      fetched = rxOutData;
    end
    if (bus.rdStrobe) begin
      next_ack     = 1'b1;
      next_devOeLo = 1'b1;
      if (!mode16 || !rdPending) rxPop = hitDword(bus.addr, OFS_DATA) && rxOutValid;
      if (!mode16) begin
        next_devData = fetched;
        next_devOeHi = 1'b1;
      end else if (!rdPending) begin
        next_rdPending = 1'b1;
        next_rdLatch   = fetched;
        next_devData   = {16'h0000, pickHalf(fetched, half)};
      end else begin
        // opposite half completes the pair; a repeated half is stale and restarts pairing
        next_rdPending = 1'b0;
        next_devData   = {16'h0000, pickHalf(rdLatch, half)};
      end
    end
    // network side: low word leaves first
    if (!txHalfValid || txHalfReady) begin
      next_txHalfValid = txOutValid;
      if (txOutValid) begin
        next_txHalf  = pickHalf(txOutData, txPhase);
        next_txPhase = !txPhase;
        txPop        = txPhase;
      end
    end
    // network side: first word received fills the low half
    if (rxHalfValid && rxHalfReady) begin
      if (!rxHave) begin
        next_rxHave = 1'b1;
        next_rxLo   = rxHalf;
      end else begin
        next_rxHave = 1'b0;
        rxPush      = 1'b1;
      end
    end
    next_rxHalfReady = (rxLevel <= RX_READY_LVL);
    next_txSpace     = txInReady && !txPush;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta   <= 1'b0;
      strapSync   <= 1'b0;
      strapTaken  <= 1'b0;
      strapAge    <= 3'h0;
      mode16      <= 1'b0;
      swapReg     <= SWAP_RESET;
      wrPending   <= 1'b0;
      wrHalf      <= 1'b0;
      stage       <= 16'h0000;
      rdPending   <= 1'b0;
      rdLatch     <= 32'h00000000;
      bus.devData <= 32'h00000000;
      bus.devOeLo <= 1'b0;
      bus.devOeHi <= 1'b0;
      bus.ack     <= 1'b0;
      bus.txSpace <= 1'b0;
      txPhase     <= 1'b0;
      txHalf      <= 16'h0000;
      txHalfValid <= 1'b0;
      rxHave      <= 1'b0;
      rxLo        <= 16'h0000;
      rxHalfReady <= 1'b0;
    end else begin
      strapMeta   <= bus.strapWidth16;
      strapSync   <= strapMeta;
      strapTaken  <= next_strapTaken;
      strapAge    <= next_strapAge;
      mode16      <= next_mode16;
      swapReg     <= next_swapReg;
      wrPending   <= next_wrPending;
      wrHalf      <= next_wrHalf;
      stage       <= next_stage;
      rdPending   <= next_rdPending;
      rdLatch     <= next_rdLatch;
      bus.devData <= next_devData;
      bus.devOeLo <= next_devOeLo;
      bus.devOeHi <= next_devOeHi;
      bus.ack     <= next_ack;
      bus.txSpace <= next_txSpace;
      txPhase     <= next_txPhase;
      txHalf      <= next_txHalf;
      txHalfValid <= next_txHalfValid;
      rxHave      <= next_rxHave;
      rxLo        <= next_rxLo;
      rxHalfReady <= next_rxHalfReady;
    end
  end
endmodule

// ===== hbwa_host.sv
// processor end: splits dword requests into bus accesses
`timescale 1ns/1ps
module hbwa_host (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  hbwa_bus_if.host                       bus,
  input  wire logic                      mode16,
  input  wire logic                      reqValid,
  input  wire logic                      reqWrite,
  input  wire logic [hbwa_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [hbwa_pkg::DATA_W-1:0] reqData,
  output logic                           reqReady,
  output logic                           respValid,
  output logic [hbwa_pkg::DATA_W-1:0]    respData
);
  import hbwa_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_ACCESS, HS_WAIT} hbwa_hstate_t;

  hbwa_hstate_t state;
  hbwa_hstate_t next_state;
  logic         isWrite;
  logic [7:0]   dwAddr;
  logic [31:0]  data;
  logic         second;
  logic [15:0]  lowRead;
  logic         next_isWrite;
  logic [7:0]   next_dwAddr;
  logic [31:0]  next_data;
  logic         next_second;
  logic [15:0]  next_lowRead;
  logic         next_reqReady;
  logic         next_respValid;
  logic [31:0]  next_respData;
  logic [7:0]   next_addr;
  logic         next_wr;
  logic         next_rd;
  logic [31:0]  next_hostData;
  logic         next_hostOe;

  always_comb begin
    next_state     = state;
    next_isWrite   = isWrite;
    next_dwAddr    = dwAddr;
    next_data      = data;
    next_second    = second;
    next_lowRead   = lowRead;
    next_reqReady  = reqReady;
    next_respValid = 1'b0;
    next_respData  = respData;
    next_addr      = bus.addr;
    next_wr        = 1'b0;
    next_rd        = 1'b0;
    next_hostData  = bus.hostData;
    next_hostOe    = 1'b0;
    case (state)
      HS_IDLE: begin
        if (reqValid && reqReady) begin
          next_isWrite  = reqWrite;
          next_dwAddr   = {reqAddr[7:2], 2'b00};
          next_data     = reqData;
          next_second   = 1'b0;
          next_reqReady = 1'b0;
          next_state    = HS_ACCESS;
        end
      end
      HS_ACCESS: begin
        // a data write waits for fifo room before its first half
        if (!(isWrite && !second && dwAddr == OFS_DATA && !bus.txSpace)) begin
          next_addr     = {dwAddr[7:2], mode16 && second, 1'b0};
          next_wr       = isWrite;
          next_rd       = !isWrite;
          next_hostOe   = isWrite;
          next_hostData = mode16 ? {16'h0000, second ? data[31:16] : data[15:0]} : data;
          next_state    = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (bus.ack) begin
          if (mode16 && !second) begin
            // low half first, then the other half of the same dword
            next_second  = 1'b1;
            next_lowRead = bus.dataBus[15:0];
            next_state   = HS_ACCESS;
          end else begin
            next_respValid = 1'b1;
            next_respData  = mode16 ? {bus.dataBus[15:0], lowRead} : bus.dataBus;
            next_reqReady  = 1'b1;
            next_state     = HS_IDLE;
          end
        end
      end
      default: begin
        next_state    = HS_IDLE;
        next_reqReady = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state            <= HS_IDLE;
      isWrite          <= 1'b0;
      dwAddr           <= 8'h00;
      data             <= 32'h00000000;
      second           <= 1'b0;
      lowRead          <= 16'h0000;
      reqReady         <= 1'b1;
      respValid        <= 1'b0;
      respData         <= 32'h00000000;
      bus.addr         <= 8'h00;
      bus.wrStrobe     <= 1'b0;
      bus.rdStrobe     <= 1'b0;
      bus.hostData     <= 32'h00000000;
      bus.hostOe       <= 1'b0;
      bus.strapWidth16 <= 1'b0;
    end else begin
      state            <= next_state;
      isWrite          <= next_isWrite;
      dwAddr           <= next_dwAddr;
      data             <= next_data;
      second           <= next_second;
      lowRead          <= next_lowRead;
      reqReady         <= next_reqReady;
      respValid        <= next_respValid;
      respData         <= next_respData;
      bus.addr         <= next_addr;
      bus.wrStrobe     <= next_wr;
      bus.rdStrobe     <= next_rd;
      bus.hostData     <= next_hostData;
      bus.hostOe       <= next_hostOe;
      bus.strapWidth16 <= mode16;
    end
  end
endmodule

// ===== hbwa_bus_assertions.sv
// concurrent checks on the host bus between the two ends
`timescale 1ns/1ps
module hbwa_bus_assertions (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        strapWidth16,
  input  wire logic [7:0]  addr,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  input  wire logic        hostOe,
  input  wire logic        devOeLo,
  input  wire logic        devOeHi,
  input  wire logic        ack,
  input  wire logic [31:0] dataBus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack_after; (wrStrobe || rdStrobe) |=> ack; endproperty
  property p_ack_cause; ack |-> $past(wrStrobe) || $past(rdStrobe); endproperty
  property p_rd_drive; rdStrobe |=> devOeLo && !hostOe; endproperty
  property p_wr_quiet; wrStrobe |-> hostOe ##1 !devOeLo && !devOeHi; endproperty
  property p_hi_idle; strapWidth16 && !hostOe |-> dataBus[31:16] == 16'h0; endproperty
  property p_no_hi16; devOeHi |-> !strapWidth16; endproperty
  property p_hi_32; rdStrobe && !strapWidth16 |=> devOeHi; endproperty
  property p_wr_pair;
    wrStrobe && strapWidth16 && !addr[1] |-> ##3 wrStrobe && addr[1] && ($past(addr, 3) >> 2) == (addr >> 2);
  endproperty
  property p_rd_pair;
    rdStrobe && strapWidth16 && !addr[1] |-> ##3 rdStrobe && addr[1] && ($past(addr, 3) >> 2) == (addr >> 2);
  endproperty
  property p_wr_pulse; wrStrobe |=> !wrStrobe; endproperty
  a_ack_after: assert property (p_ack_after) else $error("strobe without ack");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  a_rd_drive: assert property (p_rd_drive) else $error("read lanes not driven");
  a_wr_quiet: assert property (p_wr_quiet) else $error("bus clash on write");
  a_hi_idle: assert property (p_hi_idle) else $error("upper lanes not low");
  a_no_hi16: assert property (p_no_hi16) else $error("upper lanes driven in 16-bit");
  a_hi_32: assert property (p_hi_32) else $error("upper lanes idle in 32-bit");
  a_wr_pair: assert property (p_wr_pair) else $error("write pair broken");
  a_rd_pair: assert property (p_rd_pair) else $error("read pair broken");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  c_wr16: cover property (wrStrobe && strapWidth16 && addr[1]);
  c_rd16: cover property (rdStrobe && strapWidth16 ##3 rdStrobe);
  c_rd32: cover property (rdStrobe && !strapWidth16 ##1 devOeHi);
endmodule

// ===== hbwa_testbench.sv
// testbench: host and controller ends joined, plus a controller on a rule-breaking bus
`timescale 1ns/1ps
module testbench;
  import hbwa_pkg::*;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              mode16 = 1'b1;
  logic              stall = 1'b0;
  logic              sw = 1'b0;
  logic              reqValid = 1'b0;
  logic              reqWrite = 1'b0;
  logic [7:0]        reqAddr = 8'h00;
  logic [31:0]       reqData = 32'h0;
  logic              reqReady;
  logic              respValid;
  logic [31:0]       respData;
  wire  [15:0]       txHalf[2];
  wire  [1:0]        txHalfValid;
  logic              txHalfReady = 1'b0;
  logic [15:0]       rxHalf[2] = '{16'h0, 16'h0};
  logic [1:0]        rxHalfValid = 2'h0;
  wire  [1:0]        rxHalfReady;
  logic [32:0]       qResp[$];
  logic [32:0]       qBus2[$];
  logic [15:0]       qTx[$];
  logic [15:0]       qTx2[$];
  logic [32:0]       e;
  logic [31:0]       d;
  logic [31:0]       h;
  int                seed = 32'hd37f;
  int                errors = 0;
  int                checksDone = 0;
  int                cyc = 0;
  int                n;

  hbwa_bus_if bus ();
  hbwa_bus_if bus2 ();
  hbwa_host i_hbwa_host (.clk(clk), .resetn(resetn), .bus(bus.host), .mode16(mode16), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .respValid(respValid),
    .respData(respData));
  hbwa_device i_hbwa_device (.clk(clk), .resetn(resetn), .bus(bus.device), .txHalf(txHalf[0]),
    .txHalfValid(txHalfValid[0]), .txHalfReady(txHalfReady), .rxHalf(rxHalf[0]), .rxHalfValid(rxHalfValid[0]),
    .rxHalfReady(rxHalfReady[0]));
  hbwa_device i_hbwa_device_b (.clk(clk), .resetn(resetn), .bus(bus2.device), .txHalf(txHalf[1]),
    .txHalfValid(txHalfValid[1]), .txHalfReady(1'b1), .rxHalf(rxHalf[1]), .rxHalfValid(rxHalfValid[1]),
    .rxHalfReady(rxHalfReady[1]));
  hbwa_bus_assertions i_hbwa_bus_assertions (.clk(clk), .resetn(resetn), .strapWidth16(bus.strapWidth16),
    .addr(bus.addr), .wrStrobe(bus.wrStrobe), .rdStrobe(bus.rdStrobe), .hostOe(bus.hostOe),
    .devOeLo(bus.devOeLo), .devOeHi(bus.devOeHi), .ack(bus.ack), .dataBus(bus.dataBus));

  always #10 clk = ~clk;

  task automatic wrap_up();
    if (errors == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checksDone++;
    if (s !== x) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic req(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [31:0] x);
    @(negedge clk);
    while (reqReady !== 1'b1) @(negedge clk);
    reqWrite = w;
    reqAddr = a;
    reqData = v;
    reqValid = 1'b1;
    qResp.push_back({~w, x});
    @(negedge clk);
    reqValid = 1'b0;
  endtask

  task automatic wrData(input logic [31:0] v);
    req(1'b1, OFS_DATA, v, 32'h0);
    qTx.push_back(sw ? v[31:16] : v[15:0]);
    qTx.push_back(sw ? v[15:0] : v[31:16]);
  endtask

  task automatic sendRx(input int u, input logic [15:0] h0, input logic [15:0] h1);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      while (rxHalfReady[u] !== 1'b1) @(negedge clk);
      rxHalf[u] = (i == 0) ? h0 : h1;
      rxHalfValid[u] = 1'b1;
    end
    @(negedge clk);
    rxHalfValid[u] = 1'b0;
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(negedge clk);
    bus2.addr = a;
    bus2.wrStrobe = w;
    bus2.rdStrobe = ~w;
    bus2.hostOe = w;
    bus2.hostData = x;
    qBus2.push_back({~w, x});
    @(negedge clk);
    bus2.wrStrobe = 1'b0;
    bus2.rdStrobe = 1'b0;
    bus2.hostOe = 1'b0;
  endtask

  always @(negedge clk) txHalfReady <= !stall && $random(seed) % 2 != 0;

  always @(posedge clk) begin
    if (respValid) begin
      e = qResp.size() ? qResp.pop_front() : 33'h1xxxxxxxx;
      if (e[32]) chk(respData, e[31:0]);
    end
    if (bus2.ack) begin
      e = qBus2.size() ? qBus2.pop_front() : 33'h1xxxxxxxx;
      if (e[32]) chk(bus2.dataBus, e[31:0]);
    end
    if (txHalfValid[0] && txHalfReady) chk(txHalf[0], qTx.size() ? qTx.pop_front() : 32'hxxxxxxxx);
    if (txHalfValid[1]) chk(txHalf[1], qTx2.size() ? qTx2.pop_front() : 32'hxxxxxxxx);
    if (bus.ack && bus.strapWidth16) chk(bus.dataBus[31:16], 32'h0);
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    bus2.strapWidth16 = 1'b1;
    bus2.addr = 8'h00;
    bus2.wrStrobe = 1'b0;
    bus2.rdStrobe = 1'b0;
    bus2.hostOe = 1'b0;
    bus2.hostData = 32'h0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    for (int s = 0; s < 2; s++) begin
      d = s ? SWAP_ALL_ONES : 32'hfffffffe;
      req(1'b1, OFS_SWAP, d, 32'h0);
      sw = s[0];
      req(1'b0, OFS_SWAP, 32'h0, d);
      req(1'b0, OFS_CFG, 32'h0, s ? 32'h00060000 : 32'h6);
      repeat (3) wrData($random(seed));
      h = $random(seed);
      sendRx(0, h[15:0], h[31:16]);
      req(1'b0, OFS_DATA, 32'h0, s ? {h[15:0], h[31:16]} : h);
    end
    d = $random(seed);
    h = $random(seed);
    acc(1'b1, 8'h00, d);
    acc(1'b1, 8'h00, h);
    acc(1'b1, 8'h02, d);
    acc(1'b1, 8'h00, h);
    qTx2.push_back(h[15:0]);
    qTx2.push_back(d[15:0]);
    sendRx(1, d[15:0], d[31:16]);
    sendRx(1, h[15:0], h[31:16]);
    acc(1'b0, 8'h00, d[15:0]);
    acc(1'b0, 8'h00, d[15:0]);
    acc(1'b0, 8'h02, h[31:16]);
    acc(1'b0, 8'h00, h[15:0]);
    while (qTx.size() || qTx2.size() || qResp.size() || qBus2.size()) @(negedge clk);
    resetn = 1'b0;
    mode16 = 1'b0;
    sw = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    req(1'b1, OFS_SWAP, SWAP_ALL_ONES, 32'h0);
    req(1'b0, OFS_CFG, 32'h0, 32'h2);
    h = $random(seed);
    sendRx(0, h[15:0], h[31:16]);
    req(1'b0, OFS_DATA, 32'h0, h);
    stall = 1'b1;
    n = 0;
    while (bus.txSpace === 1'b1 && n < 16) begin
      wrData($random(seed));
      repeat (6) @(negedge clk);
      n++;
    end
    chk(n, FIFO_DEPTH);
    req(1'b0, OFS_CFG, 32'h0, 32'h0);
    stall = 1'b0;
    while (qTx.size() || qResp.size()) @(negedge clk);
    wrap_up();
  end
endmodule
